// *** sdsb_params.svh ***
/*
  Register indices, field positions, reset values and bit numbers of the
  serializer diagnostic status bank.
  Assumes inclusion by the bank and its monitor capture module only.
*/
`ifndef SDSB_PARAMS_SVH
`define SDSB_PARAMS_SVH
// Operation
// - Count link CRC errors in self-test mode, 8-bit read-only, resets to zero.
// - Keep 16-bit link CRC error count, low byte then high byte, reset zero.
// - Set temperature high alarm, bit 5, above upper limit; clear on read.
// - Set temperature low alarm, bit 4, below lower limit; clear on read.
// - GPIO1 voltage high sets bit 3, low sets bit 2; clear on read.
// - GPIO0 voltage high sets bit 1, low sets bit 0; clear on read.
// - Capture GPIO0 peak code above limit in bits 6:4; idle and read-clear 0.
// - Capture GPIO0 trough code below limit in bits 2:0; idle and read-clear 7.
// - Same peak and trough capture fields for the GPIO1 monitor.
// - Same peak and trough capture fields for the temperature monitor.
// - Count errored packets in 8 bits; reading the counter resets it.
// - Bit 3 flags a line shorter than its header word count; read-clear.
// - Bit 2 flags an uncorrectable payload checksum error; read-clear.
// - Bit 1 flags a two-bit header ECC error; read-clear.
// - Bit 0 flags a single-bit header ECC error; read-clear.
// - Correctable sync error per lane: bit 3 even lanes, bit 7 odd lanes.
// - Uncorrectable sync error per lane: bit 2 even lanes, bit 6 odd lanes.
// - HS request control error: bit 1 even, bit 5 odd; bits 4, 0 reserved.
// - Writing one to the link CRC clear bit zeroes the 16-bit link count; bit self-clears.
// - Writing one to the self-test clear bit zeroes its counter; bit self-clears.

// Register indices; byte address is four times the index
`define SDSB_IDX_BC_CTRL      8'h49
`define SDSB_IDX_SELFTEST_CNT 8'h54
`define SDSB_IDX_CRC_LOW      8'h55
`define SDSB_IDX_CRC_HIGH     8'h56
`define SDSB_IDX_ALARM        8'h57
`define SDSB_IDX_GPIO0_EXT    8'h58
`define SDSB_IDX_GPIO1_EXT    8'h59
`define SDSB_IDX_TEMP_EXT     8'h5a
`define SDSB_IDX_RSVD_5B      8'h5b
`define SDSB_IDX_PKT_CNT      8'h5c
`define SDSB_IDX_PKT_FLAGS    8'h5d
`define SDSB_IDX_LANES01      8'h5e
`define SDSB_IDX_LANES23      8'h5f
`define SDSB_IDX_LIMIT_GPIO0  8'ha0
`define SDSB_IDX_LIMIT_GPIO1  8'ha1
`define SDSB_IDX_LIMIT_TEMP   8'ha2

// Control bit positions
`define SDSB_BIT_CRC_CLR      3
`define SDSB_BIT_SELFTEST_CLR 5

// Field ranges of limit and extremes registers
`define SDSB_FLD_HI           6:4
`define SDSB_FLD_LO           2:0

// Reset values
`define SDSB_RST_CNT8         8'h00
`define SDSB_RST_CNT16        16'h0000
`define SDSB_RST_PEAK         3'h0
`define SDSB_RST_TROUGH       3'h7
`define SDSB_RST_LIMIT        8'h70
`define SDSB_MAX_CNT8         8'hff
`define SDSB_MAX_CNT16        16'hffff
`endif

// *** sdsb_pkg.sv ***
/*
  Types of the serializer diagnostic status bank: event carriers from the
  link receiver, CSI-2 receiver and analog monitors, and monitor state.
  Assumes all sources run on the bank clock.
*/
package sdsb_pkg;

  // Back-channel receiver events
  typedef struct packed {
    logic selftest_mode;
    logic crc_err;
  } sdsb_link_evt_t;

  // CSI-2 receiver events, one-cycle pulses
  typedef struct packed {
    logic       short_line;
    logic       payload_chk;
    logic       ecc2;
    logic       ecc1;
    logic       pkt_err;
    logic [3:0] sync_soft;
    logic [3:0] sync_hard;
    logic [3:0] hs_ctrl;
  } sdsb_csi_evt_t;

  // One monitor conversion result
  typedef struct packed {
    logic       valid;
    logic [2:0] code;
  } sdsb_mon_in_t;

  typedef sdsb_mon_in_t [2:0] sdsb_mon_arr_t;

  // Alarm and extremes state of one monitor
  typedef struct packed {
    logic       hi;
    logic       lo;
    logic [2:0] peak;
    logic [2:0] trough;
  } sdsb_mon_st_t;

  // Sticky flags of one data lane, in register bit order
  typedef struct packed {
    logic sync_soft;
    logic sync_hard;
    logic hs_ctrl;
  } sdsb_lane_flags_t;

endpackage

// *** sdsb_monitor.sv ***
/*
  Alarm flags and peak/trough capture for one voltage or temperature monitor.
  Assumes conversion results and clear strobes on the bank clock.
*/
`timescale 1ns/10ps
`include "sdsb_params.svh"

module sdsb_monitor (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Conversion input and limits
  input  wire sdsb_pkg::sdsb_mon_in_t sample,
  input  wire logic [2:0]            upper,
  input  wire logic [2:0]            lower,
  // Read-clear strobes
  input  wire logic                  clr_flags,
  input  wire logic                  clr_extremes,
  // Captured state
  output sdsb_pkg::sdsb_mon_st_t     state
);
  import sdsb_pkg::*;

  logic       above;
  logic       below;
  logic [2:0] peak_base;
  logic [2:0] trough_base;
  sdsb_mon_st_t st_r;
  sdsb_mon_st_t st_nxt;

  // Limit compare and post-clear baselines
  always_comb
  begin
    above       = sample.valid && (sample.code > upper);
    below       = sample.valid && (sample.code < lower);
    peak_base   = clr_extremes ? `SDSB_RST_PEAK : st_r.peak;
    trough_base = clr_extremes ? `SDSB_RST_TROUGH : st_r.trough;
    st_nxt.hi   = above | (st_r.hi & ~clr_flags);
    st_nxt.lo   = below | (st_r.lo & ~clr_flags);
    st_nxt.peak = (above && sample.code > peak_base) ? sample.code : peak_base;
    st_nxt.trough = (below && sample.code < trough_base) ? sample.code : trough_base;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '{hi: 1'b0, lo: 1'b0, peak: `SDSB_RST_PEAK, trough: `SDSB_RST_TROUGH};
    else
      st_r <= st_nxt;
  end

  assign state = st_r;

endmodule

// *** sdsb_bank.sv ***
/*
  Diagnostic status bank of the serializer: back-channel CRC counters,
  monitor alarms and extremes, CSI-2 packet and lane error flags, on APB.
  Assumes all event sources run on pclk and pulse for one cycle per event.
*/
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "sdsb_params.svh"

module sdsb_bank (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Event sources
  input  wire sdsb_pkg::sdsb_link_evt_t link_evt,
  input  wire sdsb_pkg::sdsb_csi_evt_t  csi_evt,
  input  wire sdsb_pkg::sdsb_mon_arr_t  mon_in
);
  import sdsb_pkg::*;

  // Address match on an aligned word at a given index
  function automatic logic sel_idx(
    input logic [11:0] addr,
    input logic [7:0]  idx
  );
    return (addr[11:10] == 2'b00) && (addr[1:0] == 2'b00) && (addr[9:2] == idx);
  endfunction

  // Saturating increment of an 8-bit count
  function automatic logic [7:0] sat_inc8(
    input logic [7:0] v
  );
    return (v == `SDSB_MAX_CNT8) ? v : v + 8'h01;
  endfunction

  // APB state
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // Decoded transfer phases
  logic        setup;
  logic        rd_setup;
  logic        wr_done;

  // Read data mux
  logic [31:0] rd_mux;
  logic        mapped;

  // Read-clear strobes
  logic        rd_alarm;
  logic        rd_pkt_cnt;
  logic        rd_pkt_flags;
  logic [1:0]  rd_lanes;
  logic [2:0]  rd_ext;

  // Control strobes and limits
  logic        crc_clr_r;
  logic        selftest_clr_r;
  logic [7:0]  limit_r [3];

  // Counters
  logic [15:0] link_crc_cnt_r;
  logic [7:0]  selftest_cnt_r;
  logic [7:0]  pkt_cnt_r;

  // Sticky flags
  logic [3:0]       pkt_flags_r;
  sdsb_lane_flags_t lane_flags_r [4];
  sdsb_mon_st_t     mon_st [3];

  // Transfer phases
  assign setup    = psel & ~penable;
  assign rd_setup = setup & ~pwrite;
  assign wr_done  = psel & penable & pwrite & pready_r;

  // Clear-on-read strobes fire at the setup edge, with data capture
  assign rd_alarm     = rd_setup & sel_idx(paddr, `SDSB_IDX_ALARM);
  assign rd_pkt_cnt   = rd_setup & sel_idx(paddr, `SDSB_IDX_PKT_CNT);
  assign rd_pkt_flags = rd_setup & sel_idx(paddr, `SDSB_IDX_PKT_FLAGS);
  assign rd_lanes[0]  = rd_setup & sel_idx(paddr, `SDSB_IDX_LANES01);
  assign rd_lanes[1]  = rd_setup & sel_idx(paddr, `SDSB_IDX_LANES23);
  assign rd_ext[0]    = rd_setup & sel_idx(paddr, `SDSB_IDX_GPIO0_EXT);
  assign rd_ext[1]    = rd_setup & sel_idx(paddr, `SDSB_IDX_GPIO1_EXT);
  assign rd_ext[2]    = rd_setup & sel_idx(paddr, `SDSB_IDX_TEMP_EXT);

  // APB answer: one access cycle, data and error set up at the setup edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_r <= 1'b0;
    else
      pready_r <= setup;
  end

  // Read data capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (rd_setup)
      prdata_r <= mapped ? rd_mux : 32'h0000_0000; // Refused reads return zero
    else
      prdata_r <= 32'h0000_0000;
  end

  // Error answer for unmapped or misaligned addresses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_r <= 1'b0;
    else if (setup)
      pslverr_r <= ~mapped;
    else
      pslverr_r <= 1'b0;
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Register read mux; narrow data in low bits, rest zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    unique case (paddr[9:2])
      `SDSB_IDX_BC_CTRL:
      begin
        rd_mux[`SDSB_BIT_CRC_CLR]      = crc_clr_r;
        rd_mux[`SDSB_BIT_SELFTEST_CLR] = selftest_clr_r;
      end
      `SDSB_IDX_SELFTEST_CNT:
        rd_mux[7:0] = selftest_cnt_r;
      `SDSB_IDX_CRC_LOW:
        rd_mux[7:0] = link_crc_cnt_r[7:0];
      `SDSB_IDX_CRC_HIGH:
        rd_mux[7:0] = link_crc_cnt_r[15:8];
      `SDSB_IDX_ALARM:
        rd_mux[7:0] = {2'b00, mon_st[2].hi, mon_st[2].lo, mon_st[1].hi,
                       mon_st[1].lo, mon_st[0].hi, mon_st[0].lo};
      `SDSB_IDX_GPIO0_EXT:
        rd_mux[7:0] = {1'b0, mon_st[0].peak, 1'b0, mon_st[0].trough};
      `SDSB_IDX_GPIO1_EXT:
        rd_mux[7:0] = {1'b0, mon_st[1].peak, 1'b0, mon_st[1].trough};
      `SDSB_IDX_TEMP_EXT:
        rd_mux[7:0] = {1'b0, mon_st[2].peak, 1'b0, mon_st[2].trough};
      `SDSB_IDX_RSVD_5B:
        rd_mux[7:0] = 8'h00;
      `SDSB_IDX_PKT_CNT:
        rd_mux[7:0] = pkt_cnt_r;
      `SDSB_IDX_PKT_FLAGS:
        rd_mux[7:0] = {4'h0, pkt_flags_r};
      `SDSB_IDX_LANES01:
        rd_mux[7:0] = {lane_flags_r[1], 1'b0, lane_flags_r[0], 1'b0};
      `SDSB_IDX_LANES23:
        rd_mux[7:0] = {lane_flags_r[3], 1'b0, lane_flags_r[2], 1'b0};
      `SDSB_IDX_LIMIT_GPIO0:
        rd_mux[7:0] = limit_r[0];
      `SDSB_IDX_LIMIT_GPIO1:
        rd_mux[7:0] = limit_r[1];
      `SDSB_IDX_LIMIT_TEMP:
        rd_mux[7:0] = limit_r[2];
      default:
        mapped = 1'b0;
    endcase
  end

  // Self-clearing clear strobes, high for one cycle after the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_clr_r      <= 1'b0;
      selftest_clr_r <= 1'b0;
    end
    else
    begin
      crc_clr_r      <= wr_done & sel_idx(paddr, `SDSB_IDX_BC_CTRL)
                        & pwdata[`SDSB_BIT_CRC_CLR];
      selftest_clr_r <= wr_done & sel_idx(paddr, `SDSB_IDX_BC_CTRL)
                        & pwdata[`SDSB_BIT_SELFTEST_CLR];
    end
  end

  // Link CRC error count, 16 bits, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      link_crc_cnt_r <= `SDSB_RST_CNT16;
    else if (crc_clr_r)
      link_crc_cnt_r <= {15'h0000, link_evt.crc_err};
    else if (link_evt.crc_err && link_crc_cnt_r != `SDSB_MAX_CNT16)
      link_crc_cnt_r <= link_crc_cnt_r + 16'h0001;
  end

  // Self-test CRC error count, only while self-test mode is on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      selftest_cnt_r <= `SDSB_RST_CNT8;
    else if (selftest_clr_r)
      selftest_cnt_r <= {7'h00, link_evt.selftest_mode & link_evt.crc_err};
    else if (link_evt.selftest_mode && link_evt.crc_err)
      selftest_cnt_r <= sat_inc8(selftest_cnt_r);
  end

  // Errored packet count, cleared by reading it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pkt_cnt_r <= `SDSB_RST_CNT8;
    else if (rd_pkt_cnt)
      pkt_cnt_r <= {7'h00, csi_evt.pkt_err};
    else if (csi_evt.pkt_err)
      pkt_cnt_r <= sat_inc8(pkt_cnt_r);
  end

  // Packet error flags, sticky, set wins over read-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pkt_flags_r <= 4'h0;
    else
    begin
      pkt_flags_r[3] <= csi_evt.short_line  | (pkt_flags_r[3] & ~rd_pkt_flags);
      pkt_flags_r[2] <= csi_evt.payload_chk | (pkt_flags_r[2] & ~rd_pkt_flags);
      pkt_flags_r[1] <= csi_evt.ecc2        | (pkt_flags_r[1] & ~rd_pkt_flags);
      pkt_flags_r[0] <= csi_evt.ecc1        | (pkt_flags_r[0] & ~rd_pkt_flags);
    end
  end

  // Per-lane sticky flags; lanes pair up into two registers
  for (genvar ln = 0; ln < 4; ln++)
  begin : g_lane
    sdsb_lane_flags_t lane_set;
    logic             lane_clr;

    assign lane_set = '{sync_soft: csi_evt.sync_soft[ln],
                        sync_hard: csi_evt.sync_hard[ln],
                        hs_ctrl:   csi_evt.hs_ctrl[ln]};
    assign lane_clr = rd_lanes[ln / 2];

    // Sticky hold until the pair register is read
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        lane_flags_r[ln] <= '0;
      else
        lane_flags_r[ln] <= lane_set | (lane_flags_r[ln] & {3{~lane_clr}});
    end
  end

  // Monitors: GPIO0, GPIO1, temperature, each with its own limit register
  for (genvar m = 0; m < 3; m++)
  begin : g_mon
    logic wr_lim;

    assign wr_lim = wr_done & sel_idx(paddr, 8'(`SDSB_IDX_LIMIT_GPIO0 + m));

    // Software-programmed upper and lower limits
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        limit_r[m] <= `SDSB_RST_LIMIT;
      else if (wr_lim)
        limit_r[m] <= {1'b0, pwdata[`SDSB_FLD_HI], 1'b0, pwdata[`SDSB_FLD_LO]};
    end

    // Alarm and extremes capture
    sdsb_monitor u_mon (
      .pclk         (pclk),
      .presetn      (presetn),
      .sample       (mon_in[m]),
      .upper        (limit_r[m][`SDSB_FLD_HI]),
      .lower        (limit_r[m][`SDSB_FLD_LO]),
      .clr_flags    (rd_alarm),
      .clr_extremes (rd_ext[m]),
      .state        (mon_st[m])
    );
  end

endmodule

// *** sdsb_bank_properties.sv ***
/*
  Port checker of the diagnostic status bank: APB answer timing, refusals,
  clear-on-read and event capture.
  Assumes binding to sdsb_bank; everything runs on pclk.
*/
`timescale 1ns/10ps

module sdsb_chk (
  // Clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB slave side
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Event sources
  input wire sdsb_pkg::sdsb_link_evt_t link_evt,
  input wire sdsb_pkg::sdsb_csi_evt_t  csi_evt,
  input wire sdsb_pkg::sdsb_mon_arr_t  mon_in
);
  import sdsb_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Read setup and write access decodes
  wire logic rd_s = psel & ~penable & ~pwrite;
  wire logic wr_a = psel & penable & pwrite;
  wire logic fq   = ~(csi_evt.short_line | csi_evt.payload_chk | csi_evt.ecc2 | csi_evt.ecc1);

  property p_ready;
    psel && !penable |=> pready && penable;
  endproperty
  a_ready: assert property (p_ready) else $error("no answer in access cycle");
  property p_refuse;
    psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("misaligned access not refused");
  property p_pkt_cnt_clr;
    rd_s && paddr == 12'h170 && !csi_evt.pkt_err ##1 !csi_evt.pkt_err [*2] ##1 rd_s && paddr == 12'h170
      |=> prdata == 32'h0;
  endproperty
  a_pkt_cnt_clr: assert property (p_pkt_cnt_clr) else $error("packet count kept after read");
  property p_pkt_cnt_inc;
    csi_evt.pkt_err ##1 rd_s && paddr == 12'h170 |=> prdata[7:0] != 8'h00;
  endproperty
  a_pkt_cnt_inc: assert property (p_pkt_cnt_inc) else $error("errored packet not counted");
  property p_flag_clr;
    rd_s && paddr == 12'h174 && fq ##1 fq [*2] ##1 rd_s && paddr == 12'h174 |=> prdata == 32'h0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("packet flags kept after read");
  property p_flag_set;
    csi_evt.ecc1 ##1 rd_s && paddr == 12'h174 |=> prdata[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("single bit header flag missing");
  property p_lane_set;
    csi_evt.sync_soft[1] ##1 rd_s && paddr == 12'h178 |=> prdata[7];
  endproperty
  a_lane_set: assert property (p_lane_set) else $error("lane 1 sync flag missing");
  property p_gpio0_idle;
    rd_s && paddr == 12'h160 && !mon_in[0].valid ##1 !mon_in[0].valid [*2] ##1 rd_s && paddr == 12'h160
      |=> prdata == 32'h7;
  endproperty
  a_gpio0_idle: assert property (p_gpio0_idle) else $error("extremes not idle after read");
  property p_st_clr;
    wr_a && paddr == 12'h124 && pwdata[5] ##1 !link_evt.crc_err ##1 rd_s && paddr == 12'h150
      |=> prdata == 32'h0;
  endproperty
  a_st_clr: assert property (p_st_clr) else $error("self-test count not cleared");

  // Main scenarios reached
  c_refuse: cover property (psel && penable && pslverr);
  c_ctrl_wr: cover property (wr_a && paddr == 12'h124);
  c_lane: cover property (csi_evt.sync_hard[3]);
endmodule

// *** sdsb_src.sv ***
/*
  Far-side model: CSI-2 receiver events, back-channel CRC errors and
  monitor conversions; events held for n cycles, a conversion for one.
  Assumes its tasks are called just after a rising pclk edge.
*/
`timescale 1ns/10ps

module sdsb_src (
  // Clock
  input wire logic                 pclk,
  // Event outputs
  output sdsb_pkg::sdsb_link_evt_t link_evt,
  output sdsb_pkg::sdsb_csi_evt_t  csi_evt,
  output sdsb_pkg::sdsb_mon_arr_t  mon_in
);
  import sdsb_pkg::*;

  // Quiet at time zero
  initial
  begin
    link_evt = '0;
    csi_evt = '0;
    mon_in = '0;
  end

  // CSI-2 events held for n cycles, one event per cycle
  task automatic csi(input sdsb_csi_evt_t v, input int n);
    csi_evt <= v;
    repeat (n) @(posedge pclk);
    csi_evt <= '0;
  endtask

  // CRC errors held for n cycles; mode level stays
  task automatic crc(input logic st, input int n);
    link_evt <= {st, 1'b1};
    repeat (n) @(posedge pclk);
    link_evt.crc_err <= 1'b0;
  endtask

  // One conversion; code inverted once stale, then a quiet edge
  task automatic conv(input int m, input logic [2:0] c);
    mon_in[m] <= {1'b1, c};
    @(posedge pclk);
    mon_in[m] <= {1'b0, ~c};
    @(posedge pclk);
  endtask
endmodule

// *** tb_serializer_diag_status_bank.sv ***
/*
  Self-checking bench of the diagnostic status bank over APB.
  Assumes the event model sdsb_src and the checker sdsb_chk.
*/
`timescale 1ns/10ps

module tb_serializer_diag_status_bank;
  import sdsb_pkg::*;
  logic           pclk;
  logic           presetn;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [11:0]    paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic [31:0]    rdv;
  logic [2:0]     hc;
  logic [2:0]     lc;
  sdsb_link_evt_t link_evt;
  sdsb_csi_evt_t  csi_evt;
  sdsb_mon_arr_t  mon_in;
  sdsb_csi_evt_t  ev;
  int             num_errors = 0;
  int             checks_done = 0;
  int             n;
  logic [7:0]     regs [16] = '{8'h49, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a,
                                8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'ha0, 8'ha1, 8'ha2};

  sdsb_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_evt(link_evt), .csi_evt(csi_evt), .mon_in(mon_in));
  sdsb_src src (.pclk(pclk), .link_evt(link_evt), .csi_evt(csi_evt), .mon_in(mon_in));

  // Clock
  always #4 pclk = ~pclk;

  // Verdict and end of run
  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, released after the answering edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1)
    begin
      num_errors++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Register read with expected byte, no error
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic e;
    apb(1'b0, {2'h0, idx, 2'h0}, 32'h0, rdv, e);
    chk(rdv, {24'h0, exp});
    chk({31'h0, e}, 32'h0);
  endtask

  // Register write
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic e;
    apb(1'b1, {2'h0, idx, 2'h0}, {24'h0, d}, rdv, e);
  endtask

  // Expected values
  function automatic logic [7:0] rst_val(input logic [7:0] i);
    return (i >= 8'h58 && i <= 8'h5a) ? 8'h07 : (i >= 8'ha0) ? 8'h70 : 8'h00;
  endfunction
  function automatic logic [7:0] lane_bit(input int l, input int t);
    return 8'((8'h08 >> t) << (4 * (l % 2)));
  endfunction

  // Main sequence
  initial
  begin
    logic e;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(12593));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rdc(regs[i], rst_val(regs[i])); // Reset values
    // Misaligned and unmapped reads are refused
    apb(1'b0, 12'h155, 32'h0, rdv, e);
    chk({31'h0, e}, 32'h1);
    chk(rdv, 32'h0);
    apb(1'b0, 12'h100, 32'h0, rdv, e);
    chk({31'h0, e}, 32'h1);
    chk(rdv, 32'h0);
    wr(8'h54, 8'hff);
    rdc(8'h54, 8'h00); // Read-only ignores write
    // Errored packets: random count, then saturation
    ev = '0;
    ev.pkt_err = 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      n = j ? 300 : 1 + $urandom_range(29);
      src.csi(ev, n);
      rdc(8'h5c, (n > 255) ? 8'hff : 8'(n)); // Count, capped
      rdc(8'h5c, 8'h00); // Cleared by read
    end
    // Back-channel CRC counts and their clears
    n = 256 + $urandom_range(99);
    src.crc(1'b1, n);
    rdc(8'h54, 8'hff); // Self-test count capped
    rdc(8'h55, n[7:0]); // Low byte
    rdc(8'h56, n[15:8]); // High byte
    wr(8'h49, 8'h08);
    rdc(8'h55, 8'h00); // Link count cleared
    rdc(8'h56, 8'h00); // Link count cleared
    wr(8'h49, 8'h20);
    rdc(8'h54, 8'h00); // Self-test count cleared
    rdc(8'h49, 8'h00); // Strobes returned to zero
    // CRC errors outside self-test mode
    src.crc(1'b0, 3);
    rdc(8'h54, 8'h00); // Not counted outside self-test
    rdc(8'h55, 8'h03); // Counted by link count
    // Packet flags, held across a growing wait
    for (int b = 0; b < 4; b++)
    begin
      ev = '0;
      ev[13 + b] = 1'b1;
      src.csi(ev, 1);
      repeat (b) @(posedge pclk);
      rdc(8'h5d, 8'(8'h01 << b)); // Flag bit
      rdc(8'h5d, 8'h00); // Cleared by read
    end
    // Every lane and every lane fault kind
    for (int l = 0; l < 4; l++)
      for (int t = 0; t < 3; t++)
      begin
        ev = '0;
        ev[8 - 4 * t + l] = 1'b1;
        src.csi(ev, 1);
        rdc(8'(8'h5e + l / 2), lane_bit(l, t)); // Lane flag
        rdc(8'(8'h5e + l / 2), 8'h00); // Cleared by read
      end
    // Monitors: limits 5 and 2, peaks and troughs at random
    for (int m = 0; m < 3; m++)
    begin
      hc = 3'h6 + 3'($urandom_range(1));
      lc = 3'($urandom_range(1));
      wr(8'(8'ha0 + m), 8'h52);
      src.conv(m, hc);
      src.conv(m, 3'h6);
      src.conv(m, 3'h3);
      src.conv(m, lc);
      src.conv(m, 3'h1);
      rdc(8'(8'h58 + m), {1'b0, hc, 1'b0, lc}); // Extremes
      rdc(8'(8'h58 + m), 8'h07); // Idle after read
      rdc(8'h57, 8'(8'h03 << (2 * m))); // Alarm pair
      rdc(8'h57, 8'h00); // Cleared by read
    end
    end_sim();
  end
endmodule

bind sdsb_bank sdsb_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .link_evt(link_evt), .csi_evt(csi_evt), .mon_in(mon_in));
